/* hdl/isolated_fast_serial_port.sv */
`timescale 1ns/1ps
// Functional notes
// - Link uses four wires: data in, clock in, data out, clear-to-send out.
// - Clear-to-send goes low while a word for the peripheral is ready.
// - Suspended with remote wakeup enabled, a low strobe requests USB resume.
// - Awake, a low strobe makes the next bulk IN send all buffered data.
// - Received data waits in a one-kilobyte receive buffer until requested.
module isolated_fast_serial_port
  import fsi_pkg::*;
#(
  parameter int unsigned RX_DEPTH = RX_BUF_BYTES
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        iso_serial_data_in,
  input  wire logic        iso_serial_clock_in,
  output logic             iso_serial_data_out,
  output logic             iso_clear_to_send_n,
  input  wire logic        flush_or_wakeup_strobe_n,
  input  wire logic        usb_power_enable_n,
  input  wire logic        remote_wakeup_en,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [7:0]  tx_data,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic [7:0]       rx_data,
  input  wire logic        bulk_in_req,
  output link_event_t      link_events
);

  if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("isolated_fast_serial_port: RX_DEPTH must be a power of two of at least 2");
  end

  fsi_state_t st;
  fsi_state_t next_st;
  logic       link_rise;
  logic       link_fall;
  logic       strobe_fall;
  logic       fifo_in_ready;
  logic       fifo_push;

  // ****************************************************
  // Receive buffer
  // ****************************************************
  // receive buffer
  word_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (RX_DEPTH)
  ) rx_buffer (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (st.rx_hold),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data),
    .full      (),
    .empty     ()
  );

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    next_st = st;
    next_st.events = '0;
    next_st.clk_sync    = {st.clk_sync[0], iso_serial_clock_in};
    next_st.din_sync    = {st.din_sync[0], iso_serial_data_in};
    next_st.strobe_sync = {st.strobe_sync[0], flush_or_wakeup_strobe_n};
    next_st.clk_prev    = st.clk_sync[1];
    next_st.strobe_prev = st.strobe_sync[1];

    link_rise   = st.clk_sync[1] && !st.clk_prev;
    link_fall   = !st.clk_sync[1] && st.clk_prev;
    strobe_fall = !st.strobe_sync[1] && st.strobe_prev;

    // hold until the buffer takes the byte
    fifo_push = st.rx_hold_valid;
    if (fifo_push && fifo_in_ready) begin
      next_st.rx_hold_valid = 1'b0;
    end

    // capture on each rising edge seen by the mclk synchroniser; levels shorter than an mclk period can be missed
    if (link_rise) begin
      next_st.rx_shift = {st.rx_shift[6:0], st.din_sync[1]};
      next_st.bit_cnt  = st.bit_cnt + 3'h1;
      if (st.bit_cnt == LAST_BIT) begin
        if (next_st.rx_hold_valid) begin
          next_st.events.rx_overrun = 1'b1;
        end else begin
          next_st.rx_hold_valid = 1'b1;
          next_st.rx_hold       = {st.rx_shift[6:0], st.din_sync[1]};
        end
      end
    end

    // Load only between words with the link clock resting low
    tx_ready = !st.tx_active && (st.bit_cnt == FIRST_BIT)
               && !st.clk_sync[1] && !st.clk_prev;

    if (link_fall && st.tx_active) begin
      if (st.bit_cnt == FIRST_BIT) begin
        next_st.tx_active = 1'b0;
        next_st.cts_n     = 1'b1;
        next_st.data_out  = DOUT_RESET;
      end else begin
        next_st.tx_shift = {st.tx_shift[6:0], 1'b0};
        next_st.data_out = st.tx_shift[6];
      end
    end else if (tx_valid && tx_ready) begin
      next_st.tx_active = 1'b1;
      next_st.tx_shift  = tx_data;
      next_st.data_out  = tx_data[7];
      next_st.cts_n     = 1'b0;
    end

    if (strobe_fall && usb_power_enable_n && remote_wakeup_en) begin
      next_st.events.resume_req = 1'b1;
    end

    // flush on next bulk IN; a new strobe wins over the clear
    if (bulk_in_req && st.flush_pending) begin
      next_st.events.send_short = 1'b1;
      next_st.flush_pending     = 1'b0;
    end
    if (strobe_fall && !usb_power_enable_n) begin
      next_st.flush_pending = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st             <= '0;
      st.strobe_sync <= STROBE_RESET;
      st.strobe_prev <= 1'b1;
      st.clk_sync    <= SYNC_RESET;
      st.rx_hold     <= BYTE_RESET;
      st.data_out    <= DOUT_RESET;
      st.cts_n       <= CTS_N_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign iso_serial_data_out = st.data_out;
  assign iso_clear_to_send_n = st.cts_n;
  assign link_events         = st.events;

  // ****************************************************
  // Checks
  // ****************************************************
  sequence load_word;
    tx_valid && tx_ready;
  endsequence

  sequence word_ends;
    link_fall && st.tx_active && (st.bit_cnt == FIRST_BIT);
  endsequence

  a_cts_on_load: assert property (
    @(posedge mclk) disable iff (!resetn)
    load_word |=> !iso_clear_to_send_n && st.tx_active)
    else $error("clear-to-send not low after a word was loaded");

  a_cts_released: assert property (
    @(posedge mclk) disable iff (!resetn)
    word_ends |=> iso_clear_to_send_n ##1 iso_clear_to_send_n || st.tx_active)
    else $error("clear-to-send still low after the word ended");

  a_cts_mid_word: assert property (
    @(posedge mclk) disable iff (!resetn)
    (st.bit_cnt != FIRST_BIT) |=> $stable(iso_clear_to_send_n))
    else $error("clear-to-send changed inside a word");

  a_dout_on_fall: assert property (
    @(posedge mclk) disable iff (!resetn)
    $changed(iso_serial_data_out) |-> $past(link_fall) || $past(tx_valid && tx_ready))
    else $error("data out changed away from a falling edge or load");

  a_resume_strobe: assert property (
    @(posedge mclk) disable iff (!resetn)
    strobe_fall && usb_power_enable_n && remote_wakeup_en |=> link_events.resume_req)
    else $error("resume not requested on wakeup strobe");

  a_resume_only_asleep: assert property (
    @(posedge mclk) disable iff (!resetn)
    link_events.resume_req |-> $past(usb_power_enable_n) && $past(remote_wakeup_en))
    else $error("resume requested while awake or wakeup disabled");

  a_flush_answer: assert property (
    @(posedge mclk) disable iff (!resetn)
    strobe_fall && !usb_power_enable_n ##1 bulk_in_req |=> link_events.send_short)
    else $error("bulk IN after strobe did not flush");

  a_rx_byte_held: assert property (
    @(posedge mclk) disable iff (!resetn)
    link_rise && (st.bit_cnt == LAST_BIT) && !st.rx_hold_valid |=> st.rx_hold_valid)
    else $error("received byte was not held");

endmodule : isolated_fast_serial_port

/* pkg/fsi_pkg.sv */
package fsi_pkg;

  // ****************************************************
  // Link word format
  // ****************************************************
  localparam int unsigned WORD_BITS     = 8;
  localparam int unsigned CNT_BITS      = 3;
  localparam logic [2:0]  LAST_BIT      = 3'h7;
  localparam logic [2:0]  FIRST_BIT     = 3'h0;

  // ****************************************************
  // Buffer sizes
  // ****************************************************
  localparam int unsigned RX_BUF_BYTES  = 1024;
  localparam int unsigned FIFO_DEPTH    = 8;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic        CTS_N_RESET   = 1'b1;
  localparam logic        DOUT_RESET    = 1'b1;
  localparam logic [1:0]  SYNC_RESET    = 2'h0;
  localparam logic [1:0]  STROBE_RESET  = 2'h3;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;

  // Events reported toward the USB engine, one-cycle pulses
  typedef struct packed {
    logic resume_req;
    logic send_short;
    logic rx_overrun;
  } link_event_t;

  typedef struct packed {
    logic [1:0] clk_sync;
    logic [1:0] din_sync;
    logic [1:0] strobe_sync;
    logic       clk_prev;
    logic       strobe_prev;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    logic       rx_hold_valid;
    logic [7:0] rx_hold;
    logic       tx_active;
    logic [7:0] tx_shift;
    logic       data_out;
    logic       cts_n;
    logic       flush_pending;
    link_event_t events;
  } fsi_state_t;

endpackage : fsi_pkg

/* hdl/word_fifo.sv */
`timescale 1ns/1ps
module word_fifo
  import fsi_pkg::*;
#(
  parameter int unsigned WIDTH = WORD_BITS,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  full,
  output logic                  empty
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Refused at elaboration: pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_params
    $error("word_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [AW-1:0]  wr_ptr;
    logic [AW-1:0]  rd_ptr;
    logic [AW:0]    count;
    logic           out_valid;
    logic [WIDTH-1:0] out_data;
  } fifo_state_t;

  logic [WIDTH-1:0] mem [DEPTH];
  fifo_state_t      st;
  fifo_state_t      next_st;
  logic             push;
  logic             pop;

  // ****************************************************
  // Pointers and output stage
  // ****************************************************
  always_comb begin
    next_st  = st;
    in_ready = (st.count < (AW+1)'(DEPTH));
    push     = in_valid && in_ready;
    // Output register refills whenever memory holds a word and the register is empty or being taken
    pop      = (st.count != '0) && (!st.out_valid || out_ready);
    if (out_ready && st.out_valid) begin
      next_st.out_valid = 1'b0;
    end
    if (pop) begin
      next_st.out_valid = 1'b1;
      next_st.out_data  = mem[st.rd_ptr];
      next_st.rd_ptr    = st.rd_ptr + 1'b1;
    end
    if (push) begin
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[st.wr_ptr] <= in_data;
    end
  end

  assign out_valid = st.out_valid;
  assign out_data  = st.out_data;
  assign full      = !in_ready;
  assign empty     = (st.count == '0) && !st.out_valid;

endmodule : word_fifo

/* sim/link_peer.sv */
`timescale 1ns/1ps
// ****************************************************
// Peripheral on the far side of the isolated link
// ****************************************************
module link_peer (
  output logic      link_clk,
  output logic      link_din,
  input  wire logic link_dout
);
  initial begin
    link_clk = 1'b0;
    link_din = 1'b0;
  end

  // One word, MSB first; the clock stands low outside frames
  task automatic frame(input logic [7:0] b, input int half, output logic [7:0] got);
    #7;
    for (int i = 7; i >= 0; i--) begin
      link_din = b[i];
      #(half);
      link_clk = 1'b1;
      got[i]   = link_dout;
      #(half);
      link_clk = 1'b0;
    end
    #(half);
    // Released line shows the inverse so a stale sample cannot pass
    link_din = ~b[0];
  endtask : frame
endmodule : link_peer

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import fsi_pkg::*;
  logic        mclk, resetn, sdin, sclk, sdout, cts_n, strobe_n, pwr_n, wake_en;
  logic        tx_valid, tx_ready, rx_valid, rx_ready, bulk_in_req, fill;
  logic [7:0]  tx_data, rx_data;
  link_event_t ev;
  logic [7:0]  exp_q[$];
  int          num_errors, total_checks, cycles, n_res, n_short, n_ovr;
  int          seed = 32'ha816_edf0;

  isolated_fast_serial_port #(.RX_DEPTH(8)) dut_u (
    .mclk(mclk), .resetn(resetn), .iso_serial_data_in(sdin),
    .iso_serial_clock_in(sclk), .iso_serial_data_out(sdout),
    .iso_clear_to_send_n(cts_n), .flush_or_wakeup_strobe_n(strobe_n),
    .usb_power_enable_n(pwr_n), .remote_wakeup_en(wake_en), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .bulk_in_req(bulk_in_req), .link_events(ev));
  link_peer peer_u (.link_clk(sclk), .link_din(sdin), .link_dout(sdout));

  // ****************************************************
  // Checking and verdict
  // ****************************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    rx_ready <= fill ? 1'b0 : 1'($random(seed));
    if (ev.resume_req === 1'b1) n_res++;
    if (ev.send_short === 1'b1) n_short++;
    if (ev.rx_overrun === 1'b1) n_ovr++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      // buffered bytes leave in arrival order
      check("rx_data", rx_data, exp_q.size() > 0 ? exp_q.pop_front() : ~rx_data);
    end
    if (cycles == 60000) begin
      num_errors++;
      give_verdict();
    end
  end

  // ****************************************************
  // Stimulus
  // ****************************************************
  task automatic xfer(input logic load, input int half);
    logic [7:0] got, rxb, txb;
    rxb = 8'($random(seed));
    txb = 8'($random(seed));
    if (load) begin
      @(posedge mclk);
      tx_valid <= 1'b1;
      tx_data  <= txb;
      for (int i = 0; i < 200; i++) begin
        @(posedge mclk);
        if (tx_ready === 1'b1) break;
      end
      tx_valid <= 1'b0;
      repeat (2) @(posedge mclk);
      // low once a word is ready
      check("cts_load", 8'(cts_n), 8'h00);
    end
    exp_q.push_back(rxb);
    peer_u.frame(rxb, half, got);
    repeat (8) @(posedge mclk);
    check("cts_end", 8'(cts_n), 8'h01);
    // whole word MSB first, idle high
    check("tx_word", got, load ? txb : 8'hff);
  endtask : xfer

  task automatic strobe(input logic pen, input logic wake, input logic quick);
    int r0, s0;
    r0 = n_res;
    s0 = n_short;
    @(posedge mclk);
    pwr_n <= pen;
    wake_en <= wake;
    bulk_in_req <= 1'b1;
    @(posedge mclk);
    bulk_in_req <= 1'b0;
    repeat (3) @(posedge mclk);
    strobe_n <= 1'b0;
    repeat (3) @(posedge mclk);
    // Quick form: bulk IN lands one cycle after the synced strobe edge
    bulk_in_req <= quick;
    @(posedge mclk);
    bulk_in_req <= 1'b0;
    strobe_n <= 1'b1;
    repeat (8) @(posedge mclk);
    // resume only when suspended with wakeup enabled
    check("resume", 8'(n_res - r0), 8'(pen & wake));
    bulk_in_req <= !quick;
    @(posedge mclk);
    bulk_in_req <= 1'b0;
    repeat (3) @(posedge mclk);
    // flush on the next bulk IN only when awake
    check("send_short", 8'(n_short - s0), 8'(!pen));
  endtask : strobe

  initial begin
    {resetn, tx_valid, tx_data, bulk_in_req, fill, pwr_n, wake_en} = '0;
    strobe_n = 1'b1;
    repeat (10) @(posedge mclk);
    check("reset_lines", {6'h00, cts_n, sdout}, 8'h03);
    resetn <= 1'b1;
    for (int k = 0; k < 8; k++) xfer(1'($random(seed)) | k < 2, k[0] ? 250 : 100);
    fill <= 1'b1;
    for (int k = 0; k < 14; k++) xfer(1'b0, 100);
    check("overrun", 8'(n_ovr > 0), 8'h01);
    fill <= 1'b0;
    repeat (60) @(posedge mclk);
    check("drained", 8'(rx_valid), 8'h00);
    exp_q.delete();
    strobe(1'b1, 1'b1, 1'b0);
    strobe(1'b1, 1'b0, 1'b1);
    strobe(1'b0, 1'b0, 1'b0);
    strobe(1'b0, 1'b1, 1'b1);
    give_verdict();
  end
endmodule : testbench
